// ===== src/io_expander_consts.svh
// Register addresses, field positions and reset values of the serial I/O expander.
`ifndef IO_EXPANDER_CONSTS_SVH
`define IO_EXPANDER_CONSTS_SVH
`define ADDR_NOOP        7'h00
`define ADDR_CONFIG      7'h04
`define ADDR_MASK        7'h06
`define ADDR_PCFG_FIRST  7'h09
`define ADDR_PCFG_LAST   7'h0f
`define ADDR_SINGLE_LO   7'h20
`define ADDR_SINGLE_HI   7'h3f
`define ADDR_MULTI_LO    7'h40
`define ADDR_MULTI_HI    7'h5f
`define CFG_BIT_RUN      0
`define CFG_BIT_ARM      7
`define FIRST_PORT       5'h04
`define NUM_PORTS        28
`define WATCH_LO         20
`define ALERT_IDX        27
`define PCFG_RESET       56'haaaa_aaaa_aaaa_aa
`define PCFG_OUT         2'h1
`define PCFG_IN_PULL     2'h3
`define FRAME_BITS       16
`endif

// ===== src/io_expander_pkg.sv
// Types shared by the serial I/O expander design.
package io_expander_pkg;
  typedef logic [1:0] sync_t;
  typedef struct packed {
    logic        armed;
    logic        alert;
    logic [6:0]  snap;
    logic [6:0]  mask;
    logic [7:0]  cfg;
    logic [27:0] pdata;
    logic [55:0] pcfg;
    logic [15:0] shreg;
    logic        dout;
  } state_s;
endpackage

// ===== src/pin_sync.sv
// Two-flip-flop synchroniser for one asynchronous input.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output var  logic sync_out
);
  io_expander_pkg::sync_t stage_r;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage_r <= {2{RST_VAL}};
    end else begin
      stage_r <= {stage_r[0], async_in};
    end
  end
  assign sync_out = stage_r[1];
endmodule
`default_nettype wire

// ===== src/serial_io_expander_control.sv
// Serial control front end and transition detector of a 28-port I/O expander.
`timescale 1ns/100ps
`default_nettype none
`include "io_expander_consts.svh"
module serial_io_expander_control (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Serial link
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic        din,
  output var  logic        dout,
  // Port pins P4..P31 at index 0..27
  input  wire logic [27:0] port_in,
  output var  logic [27:0] port_out,
  output var  logic [27:0] port_oe_b,
  output var  logic [27:0] port_pullup,
  // Status
  output var  logic        shutdown,
  output var  logic        alert_port
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic        sclk_s;
  logic        cs_b_s;
  logic        din_s;
  logic [27:0] pins_s;
  logic        sclk_d_r;
  logic        cs_b_d_r;

  pin_sync u_sync_sclk (.clock(clock), .rst_b(rst_b), .async_in(sclk), .sync_out(sclk_s));
  // Select idles high so that leaving reset does not look like a select rise.
  pin_sync #(.RST_VAL(1'b1)) u_sync_cs (.clock(clock), .rst_b(rst_b), .async_in(cs_b), .sync_out(cs_b_s));
  pin_sync u_sync_din  (.clock(clock), .rst_b(rst_b), .async_in(din),  .sync_out(din_s));

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PORTS; gi++) begin : g_pin
      pin_sync u_sync_pin (.clock(clock), .rst_b(rst_b), .async_in(port_in[gi]), .sync_out(pins_s[gi]));
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sclk_d_r <= 1'b0;
      cs_b_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_b_d_r <= cs_b_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_b_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_b_s;
  assign cs_rise   = cs_b_s & ~cs_b_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Port register helpers.
  io_expander_pkg::state_s st_r;
  io_expander_pkg::state_s st_nxt;

  // Value read back for one port: data bit for outputs, pin level for inputs.
  function automatic logic port_value(input int idx, input io_expander_pkg::state_s s,
                                      input logic [27:0] pins);
    logic [1:0] pair;
    pair = s.pcfg[2*idx +: 2];
    if (pair == `PCFG_OUT) begin
      port_value = s.pdata[idx];
    end else begin
      port_value = pins[idx];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  logic [15:0] latch;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        is_read;
  logic [6:0]  watched;
  logic        arm_wr;
  int          first;
  int          cnt;
  int          p;
  int          k;

  always_comb begin
    st_nxt  = st_r;
    latch   = st_r.shreg;
    is_read = latch[15];
    addr    = latch[14:8];
    wdata   = latch[7:0];
    rdata   = 8'h00;
    first   = 0;
    cnt     = 0;
    p       = 0;
    watched = pins_s[`WATCH_LO +: 7];
    arm_wr  = 1'b0;

    if (sclk_rise) begin
      st_nxt.shreg = {st_r.shreg[14:0], din_s};
    end
    if (sclk_fall) begin
      st_nxt.dout = st_r.shreg[15];
    end

    if (cs_rise) begin
      // Work out the port span addressed by a single or multi-port command.
      if (addr >= `ADDR_SINGLE_LO && addr <= `ADDR_SINGLE_HI) begin
        first = int'(addr - `ADDR_SINGLE_LO);
        cnt   = 1;
      end else if (addr >= `ADDR_MULTI_LO && addr <= `ADDR_MULTI_HI) begin
        first = int'(addr - `ADDR_MULTI_LO);
        cnt   = 8;
      end
      if (addr >= `ADDR_PCFG_FIRST && addr <= `ADDR_PCFG_LAST) begin
        rdata = st_r.pcfg[8*int'(addr - `ADDR_PCFG_FIRST) +: 8];
      end else if (addr == `ADDR_CONFIG) begin
        rdata = st_r.cfg;
      end else if (addr == `ADDR_MASK) begin
        rdata = {1'b0, st_r.mask};
      end
      for (k = 0; k < 8; k++) begin
        p = first + k - 4;
        if (k < cnt && p >= 0 && p < `NUM_PORTS) begin
          rdata[k] = port_value(p, st_r, pins_s);
        end
      end

      if (is_read) begin
        st_nxt.shreg = {latch[15:8], rdata};
        if (addr == `ADDR_MASK) begin
          st_nxt.alert = 1'b0;
        end
      end else begin
        if (addr >= `ADDR_PCFG_FIRST && addr <= `ADDR_PCFG_LAST) begin
          st_nxt.pcfg[8*int'(addr - `ADDR_PCFG_FIRST) +: 8] = wdata;
        end else if (addr == `ADDR_CONFIG) begin
          st_nxt.cfg = wdata;
          st_nxt.armed = wdata[`CFG_BIT_ARM];
          arm_wr       = wdata[`CFG_BIT_ARM];
          if (wdata[`CFG_BIT_ARM]) begin
            st_nxt.snap  = watched;
            st_nxt.alert = 1'b0;
          end
        end else if (addr == `ADDR_MASK) begin
          st_nxt.mask  = wdata[6:0];
          st_nxt.alert = 1'b0;
        end
        for (k = 0; k < 8; k++) begin
          p = first + k - 4;
          if (k < cnt && p >= 0 && p < `NUM_PORTS) begin
            st_nxt.pdata[p] = wdata[k];
          end
        end
      end
    end

    // Transition detector runs on pin levels whatever the port direction.
    // It is applied last so that a change in the cycle of a mask access still
    // latches the alert; a fresh arming write takes a new snapshot instead.
    if (st_r.armed && !arm_wr && ((watched ^ st_r.snap) & st_r.mask) != 7'h00) begin
      st_nxt.alert = 1'b1;
      st_nxt.armed = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r.armed <= 1'b0;
      st_r.alert <= 1'b0;
      st_r.snap  <= 7'h00;
      st_r.mask  <= 7'h00;
      st_r.cfg   <= 8'h00;
      st_r.pdata <= 28'h0000000;
      st_r.pcfg  <= `PCFG_RESET;
      st_r.shreg <= 16'h0000;
      st_r.dout  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive.
  assign dout     = st_r.dout;
  assign shutdown = ~st_r.cfg[`CFG_BIT_RUN];

  always_comb begin
    for (int i = 0; i < `NUM_PORTS; i++) begin
      port_out[i]    = st_r.pdata[i];
      port_oe_b[i]   = shutdown | (st_r.pcfg[2*i +: 2] != `PCFG_OUT);
      port_pullup[i] = ~shutdown & (st_r.pcfg[2*i +: 2] == `PCFG_IN_PULL);
    end
    port_out[`ALERT_IDX] = st_r.alert;
  end
  assign alert_port = st_r.alert;

endmodule
`default_nettype wire

// ===== bench/expander_monitor.sv
// Port-level checks of the expander control block.
`timescale 1ns/100ps
`default_nettype none
module expander_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Serial link
  input wire logic        cs_b,
  input wire logic        dout,
  // Ports and status
  input wire logic [27:0] port_oe_b,
  input wire logic [27:0] port_pullup,
  input wire logic        shutdown,
  input wire logic        alert_port
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rst_vals;
    disable iff (1'b0) !rst_b |=> shutdown && !alert_port && !dout && port_oe_b == 28'hfffffff;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_idle_dout;
    cs_b [*8] |-> $stable(dout);
  endproperty
  a_idle_dout: assert property (p_idle_dout) else $error("dout moved while deselected");
  property p_cfg_hold;
    !cs_b [*8] |-> $stable(port_oe_b) && $stable(port_pullup) && $stable(shutdown);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("port setup moved mid frame");
  property p_alert_hold;
    !cs_b [*6] ##0 alert_port |=> alert_port;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped while latched");
  property p_alert_clear;
    $fell(alert_port) |-> cs_b;
  endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("alert cleared without access");
  property p_shut;
    shutdown |-> port_oe_b == 28'hfffffff && port_pullup == 28'h0;
  endproperty
  a_shut: assert property (p_shut) else $error("port active in shutdown");
  property p_mode;
    (~port_oe_b & port_pullup) == 28'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("pullup on driven port");
  property p_dout_sel;
    $changed(dout) |-> !$past(cs_b, 4);
  endproperty
  a_dout_sel: assert property (p_dout_sel) else $error("dout moved outside a frame");
  c_alert_set: cover property ($rose(alert_port));
  c_alert_clr: cover property ($fell(alert_port));
  c_run: cover property ($fell(shutdown));
endmodule
bind serial_io_expander_control expander_monitor i_expander_monitor (.clock(clock), .rst_b(rst_b),
  .cs_b(cs_b), .dout(dout), .port_oe_b(port_oe_b), .port_pullup(port_pullup), .shutdown(shutdown),
  .alert_port(alert_port));
`default_nettype wire

// ===== bench/spi_host_model.sv
// Host side of the serial link: frames with echo capture, and idle noise.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Clock
  input  wire logic clock,
  // Serial link
  output var  logic sclk,
  output var  logic cs_b,
  output var  logic din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    din  = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clock);
  endtask
  // Optional eight leading ones test that only the last sixteen bits count.
  task automatic xfer(input bit extra, input logic [15:0] tx, output logic [15:0] rx);
    logic [23:0] bits;
    bits = {8'hff, tx};
    cs_b = 1'b0;
    half();
    for (int i = extra ? 23 : 15; i >= 0; i--) begin
      din = bits[i];
      half();
      sclk = 1'b1;
      rx = {rx[14:0], dout};
      half();
      sclk = 1'b0;
    end
    half();
    cs_b = 1'b1;
    din = ~din;
    half();
  endtask
  // Traffic meant for another peripheral while this one is deselected.
  task automatic noise();
    repeat (12) begin
      sclk = ~sclk;
      din = ~din;
      half();
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/serial_io_expander_control_bench.sv
// Self-checking bench for the serial I/O expander control block.
`timescale 1ns/100ps
`default_nettype none
module serial_io_expander_control_bench;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        sclk, cs_b, din, dout, shutdown, alert_port;
  logic [27:0] port_in = 28'h0;
  logic [27:0] port_out, port_oe_b, port_pullup;
  logic [15:0] rx;
  int          mismatches = 0;
  int          comparisons = 0;
  always #5 clock = ~clock;
  spi_host_model i_spi_host_model (.clock(clock), .sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout));
  serial_io_expander_control i_serial_io_expander_control (.clock(clock), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .din(din), .dout(dout), .port_in(port_in), .port_out(port_out), .port_oe_b(port_oe_b),
    .port_pullup(port_pullup), .shutdown(shutdown), .alert_port(alert_port));
  task automatic check(input logic [27:0] seen, input logic [27:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic frame(input logic [15:0] w);
    i_spi_host_model.xfer(1'b0, w, rx);
  endtask
  task automatic pulse(input int idx);
    port_in[idx] = 1'b1;
    repeat (5) @(negedge clock);
    port_in[idx] = 1'b0;
    repeat (8) @(negedge clock);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #500us;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    check(shutdown, 1'b1);
    frame(16'h8400);
    frame(16'h0000);
    check(rx[7:0], 8'h00);
    $display("reset test done");
    frame(16'h0401);
    check(shutdown, 1'b0);
    frame(16'h0955);
    frame(16'h0f7e);
    check(port_oe_b[27:24], 4'h7);
    check(port_pullup[27:24], 4'h6);
    check(port_oe_b[4:0], 5'h10);
    frame(16'h4409);
    check(port_out[3:0], 4'h9);
    frame(16'h2501);
    port_in[4] = 1'b1;
    frame(16'hc400);
    frame(16'h0000);
    check(rx[7:0], 8'h1b);
    check(rx[14:8], 7'h44);
    $display("port test done");
    i_spi_host_model.xfer(1'b1, 16'h2400, rx);
    check(port_out[3:0], 4'ha);
    frame(16'h2601);
    i_spi_host_model.noise();
    check(port_out[3:0], 4'he);
    frame(16'h0000);
    check(rx[14:0], 15'h2601);
    $display("framing test done");
    frame(16'h0603);
    frame(16'h0481);
    check(alert_port, 1'b0);
    pulse(22);
    check(alert_port, 1'b0);
    pulse(20);
    check(alert_port, 1'b1);
    check(port_out[27], 1'b1);
    frame(16'h8600);
    check(alert_port, 1'b0);
    pulse(21);
    check(alert_port, 1'b0);
    frame(16'h0000);
    check(rx[7:0], 8'h03);
    frame(16'h0481);
    pulse(21);
    check(alert_port, 1'b1);
    frame(16'h0481);
    check(alert_port, 1'b0);
    frame(16'h0401);
    pulse(20);
    check(alert_port, 1'b0);
    $display("detection test done");
    print_verdict();
  end
endmodule
`default_nettype wire
